// >>> include/pcx_consts.svh
// named offsets, bit positions and codes of the queue-group counter block
// assumes inclusion by bare name from design files
`ifndef PCX_CONSTS_SVH
`define PCX_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PCX_CFG_BASE 8'h00
`define PCX_CNT_BASE 8'h20
`define PCX_SEL_BASE 8'h40
`define PCX_STAT_ADDR 8'h50
`define PCX_MASK_ADDR 8'h54
`define PCX_CTRL_ADDR 8'h58

// ----------------------------------------
// block shape
// ----------------------------------------
`define PCX_GRP_N 3'h6
`define PCX_SEL_N 3'h3

// ----------------------------------------
// configuration and control register fields
// ----------------------------------------
`define PCX_EN_BIT 0
`define PCX_CHAIN_BIT 1
`define PCX_WRAPIRQ_BIT 2
`define PCX_FORCE_BIT 3
`define PCX_EXT_BIT 11
`define PCX_OVF_BIT 31
`define PCX_HOLD_BIT 0

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define PCX_WORD_RST 32'h0000_0000
`define PCX_NULL_SEL 4'h0
`define PCX_RESP_OKAY 2'h0
`define PCX_RESP_SLVERR 2'h2
`define PCX_FAMILY_EXT 8'h0f
`define PCX_MODEL_EXT_MIN 8'h02

`endif

// >>> include/pcx_pkg.sv
// types shared by the queue-group counter block
// assumes nothing of its surroundings
package pcx_pkg;
   typedef logic [31:0] pcx_word_t;
   typedef logic [2:0] pcx_idx_t;
   typedef logic [7:0] pcx_addr_t;
endpackage

// >>> design/pcx_perf_counter.sv
// six-counter queue group: chaining, extended chaining, overflow interrupt
// assumes AXI4-Lite master on mclk, event lines and interrupt accept on mclk
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcx_consts.svh"

// Functional notes
// - bit 11 extended chain; groups 1,2 reserved
// - cfg0/cfg5 bit lets counter 4 start 0/5
// - cfg3/cfg4 bit lets counter 5 start 3/4
// - counters 4,5 start others only via extension
// - extended chain starts target with enable clear
// - extension chosen by target's bit, not chain flag
// - extension only for family 15, model >=2
// - wrap with irq flag raises interrupt
// - interrupt goes out to local interrupt controller
// - sticky overflow flags stay readable
// - accepted interrupt masks further until software clears
// - interrupt on event after the wrapping one
// - forced wrap makes every increment overflow
// - idle event select yields no counts
// - null select zero counts nothing
// - wrap continues counting, sets sticky flag
// - overflow starts chained alternate counter
// - chained counter stops on flag clear
module pcx_perf_counter
   import pcx_pkg::*;
#(
   parameter logic [7:0] FAMILY = 8'h0f,
   parameter logic [7:0] MODEL = 8'h02,
   parameter int EV_N = 16
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // axi4-lite write
   input wire pcx_addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire pcx_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire pcx_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output pcx_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // event lines
   input wire logic [EV_N-1:0] event_in,
   // local interrupt controller
   output logic counter_overflow_irq,
   input wire logic irq_accept
);

   localparam bit EXT_OK = (FAMILY == `PCX_FAMILY_EXT) && (MODEL >= `PCX_MODEL_EXT_MIN);

   // ----------------------------------------
   // chaining maps
   // ----------------------------------------
   // ordinary source never names 4 or 5, so those only start others via extension
   function automatic pcx_idx_t ord_src(input int i);
      case (i)
         0: return 3'h2;
         1: return 3'h3;
         2: return 3'h0;
         3: return 3'h1;
         4: return 3'h2;
         default: return 3'h3;
      endcase
   endfunction

   function automatic pcx_idx_t ext_src(input int i);
      case (i)
         0: return 3'h4;
         3: return 3'h5;
         4: return 3'h5;
         default: return 3'h4;
      endcase
   endfunction

   function automatic logic in_blk(input pcx_addr_t a, input pcx_addr_t base, input pcx_idx_t n);
      return (a[7:5] == base[7:5]) && (a[4:2] < n) && (a[1:0] == 2'h0);
   endfunction

   function automatic pcx_word_t merge(input pcx_word_t old, input pcx_word_t nw, input logic [3:0] st);
      pcx_word_t m;
      m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [5:0] en, chn, wirq, frc, ext, ovf, arm, stat, mask;
   logic [5:0] run, inc, wrap_ev, wr_cfg, wr_cnt, stat_set;
   logic [2:0] sel_act;
   logic hold;
   pcx_word_t cnt [6];
   logic [3:0] sel [3];
   pcx_word_t cfg_rd [6];

   // ----------------------------------------
   // axi write channel
   // ----------------------------------------
   logic aw_full, w_full, wr_do, wr_ok;
   logic next_aw_full, next_w_full;
   pcx_addr_t wa;
   pcx_word_t wd;
   logic [3:0] ws;
   pcx_idx_t wi;

   assign next_aw_full = aw_full ? !wr_do : (s_axi_awvalid && s_axi_awready);
   assign next_w_full = w_full ? !wr_do : (s_axi_wvalid && s_axi_wready);
   // one write in flight: the response must drain before the next is committed
   assign wr_do = aw_full && w_full && !s_axi_bvalid;
   assign wi = wa[4:2];
   assign wr_ok = in_blk(wa, `PCX_CFG_BASE, `PCX_GRP_N) || in_blk(wa, `PCX_CNT_BASE, `PCX_GRP_N)
      || in_blk(wa, `PCX_SEL_BASE, `PCX_SEL_N) || wa == `PCX_STAT_ADDR || wa == `PCX_MASK_ADDR
      || wa == `PCX_CTRL_ADDR;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= !next_aw_full;
         s_axi_wready <= !next_w_full;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         wa <= 8'h00;
         wd <= `PCX_WORD_RST;
         ws <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wd <= s_axi_wdata;
            ws <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PCX_RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `PCX_RESP_OKAY : `PCX_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ----------------------------------------
   // per-counter logic
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : gen_cnt
         localparam bit HAS_EXT = (g != 1) && (g != 2);
         pcx_word_t cw;

         assign wr_cfg[g] = wr_do && in_blk(wa, `PCX_CFG_BASE, `PCX_GRP_N) && wi == 3'(g);
         assign wr_cnt[g] = wr_do && in_blk(wa, `PCX_CNT_BASE, `PCX_GRP_N) && wi == 3'(g);
         assign cw = merge(cfg_rd[g], wd, ws);

         // chained run lasts only while chain bit and source flag both hold
         assign run[g] = en[g] || (chn[g] && ovf[ord_src(g)])
            || (EXT_OK && HAS_EXT && ext[g] && ovf[ext_src(g)]);
         assign inc[g] = run[g] && sel_act[g/2] && sel[g/2] != `PCX_NULL_SEL
            && event_in[sel[g/2]];
         assign wrap_ev[g] = inc[g] && (frc[g] || &cnt[g]);
         assign stat_set[g] = wirq[g] && inc[g] && (frc[g] || arm[g]);

         assign cfg_rd[g] = {ovf[g], 19'h0, HAS_EXT ? ext[g] : 1'b0, 7'h0, frc[g], wirq[g], chn[g], en[g]};

         always_ff @(posedge mclk)
         begin
            if (reset)
            begin
               en[g] <= 1'b0;
               chn[g] <= 1'b0;
               wirq[g] <= 1'b0;
               frc[g] <= 1'b0;
               ext[g] <= 1'b0;
            end
            else if (wr_cfg[g])
            begin
               en[g] <= cw[`PCX_EN_BIT];
               chn[g] <= cw[`PCX_CHAIN_BIT];
               wirq[g] <= cw[`PCX_WRAPIRQ_BIT];
               frc[g] <= cw[`PCX_FORCE_BIT];
               ext[g] <= HAS_EXT && cw[`PCX_EXT_BIT];
            end
         end

         // sticky flag: a wrap in the clearing cycle wins
         always_ff @(posedge mclk)
         begin
            if (reset)
               ovf[g] <= 1'b0;
            else if (wrap_ev[g])
               ovf[g] <= 1'b1;
            else if (wr_cfg[g])
               ovf[g] <= ovf[g] && cw[`PCX_OVF_BIT];
         end

         always_ff @(posedge mclk)
         begin
            if (reset)
               cnt[g] <= `PCX_WORD_RST;
            else if (wr_cnt[g])
               cnt[g] <= merge(cnt[g], wd, ws);
            else if (inc[g])
               cnt[g] <= cnt[g] + 32'h1;
         end

         // the wrap itself only arms; the next counted event fires
         always_ff @(posedge mclk)
         begin
            if (reset)
               arm[g] <= 1'b0;
            else if (wrap_ev[g] && !frc[g] && wirq[g])
               arm[g] <= 1'b1;
            else if (inc[g] || !wirq[g])
               arm[g] <= 1'b0;
         end
      end

      for (g = 0; g < 3; g++)
      begin : gen_sel
         // paired selector keeps selectors 0 and 1 powered; selector 2 is powered only by its own pair
         assign sel_act[g] = |run[2*g+:2] || |run[2*((g < 2) ? (g ^ 1) : g)+:2];

         always_ff @(posedge mclk)
         begin
            if (reset)
               sel[g] <= `PCX_NULL_SEL;
            else if (wr_do && in_blk(wa, `PCX_SEL_BASE, `PCX_SEL_N) && wi == 3'(g))
               sel[g] <= 4'(merge({28'h0, sel[g]}, wd, ws));
         end
      end
   endgenerate

   // ----------------------------------------
   // interrupt status, mask and hold
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
         stat <= 6'h00;
      else if (wr_do && wa == `PCX_STAT_ADDR && ws[0])
         stat <= (stat & ~wd[5:0]) | stat_set;
      else
         stat <= stat | stat_set;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         mask <= 6'h00;
      else if (wr_do && wa == `PCX_MASK_ADDR && ws[0])
         mask <= wd[5:0];
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         hold <= 1'b0;
      else if (irq_accept && counter_overflow_irq)
         hold <= 1'b1;
      else if (wr_do && wa == `PCX_CTRL_ADDR && ws[0] && wd[`PCX_HOLD_BIT])
         hold <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         counter_overflow_irq <= 1'b0;
      else
         counter_overflow_irq <= |(stat & mask) && !hold && !(irq_accept && counter_overflow_irq);
   end

   // ----------------------------------------
   // axi read channel
   // ----------------------------------------
   logic next_rvalid;
   pcx_word_t rd_mux;
   logic rd_ok;

   assign next_rvalid = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);

   always_comb
   begin
      rd_mux = `PCX_WORD_RST;
      rd_ok = 1'b1;
      if (in_blk(s_axi_araddr, `PCX_CFG_BASE, `PCX_GRP_N))
         rd_mux = cfg_rd[s_axi_araddr[4:2]];
      else if (in_blk(s_axi_araddr, `PCX_CNT_BASE, `PCX_GRP_N))
         rd_mux = cnt[s_axi_araddr[4:2]];
      else if (in_blk(s_axi_araddr, `PCX_SEL_BASE, `PCX_SEL_N))
         rd_mux = {28'h0, sel[s_axi_araddr[3:2]]};
      else if (s_axi_araddr == `PCX_STAT_ADDR)
         rd_mux = {26'h0, stat};
      else if (s_axi_araddr == `PCX_MASK_ADDR)
         rd_mux = {26'h0, mask};
      else if (s_axi_araddr == `PCX_CTRL_ADDR)
         rd_mux = {31'h0, hold};
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= `PCX_WORD_RST;
         s_axi_rresp <= `PCX_RESP_OKAY;
      end
      else
      begin
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= !next_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `PCX_RESP_OKAY : `PCX_RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_wrap_armed;
      wrap_ev[0] && wirq[0] && !frc[0];
   endsequence

   sequence s_next_event;
      inc[0] && !wr_cfg[0];
   endsequence

   a_wrap_sets_flag: assert property (wrap_ev[0] |=> ovf[0] && (~|cnt[0] || $past(frc[0]) || $past(wr_cnt[0])))
      else $error("wrap did not set overflow flag");
   a_irq_after_wrap: assert property (s_wrap_armed ##1 s_next_event |=> stat[0])
      else $error("status missing on event after wrap");
   a_wrap_no_status: assert property (s_wrap_armed and (!arm[0] && !stat[0] && !wr_cfg[0]) |=> !stat[0])
      else $error("status set by the wrapping event itself");
   a_forced_each: assert property (inc[2] && frc[2] && wirq[2] |=> stat[2] && ovf[2])
      else $error("forced increment not treated as overflow");
   a_ext_four_zero: assert property (wrap_ev[4] && ext[0] && !wr_cfg[0] && !wr_cfg[4] |=> run[0] == EXT_OK)
      else $error("extended chain 4 into 0 wrong");
   a_ext_five_three: assert property (wrap_ev[5] && ext[3] && !wr_cfg[3] && !wr_cfg[5] |=> run[3] == EXT_OK)
      else $error("extended chain 5 into 3 wrong");
   a_ordinary_no_ext: assert property (!en[0] && !ext[0] && !ovf[2] |-> !run[0])
      else $error("counter 0 ran without a source");
   a_irq_raise: assert property (|(stat & mask) && !hold && !irq_accept |=> counter_overflow_irq)
      else $error("unmasked status did not raise interrupt");
   a_accept_masks: assert property (irq_accept && counter_overflow_irq |=> hold ##1 !counter_overflow_irq)
      else $error("accepted interrupt not masked");
   a_null_no_count: assert property (sel[0] == `PCX_NULL_SEL && !wr_cnt[0] |=> cnt[0] == $past(cnt[0]))
      else $error("null select counted");
   a_status_sticky: assert property (stat[0] && !(wr_do && wa == `PCX_STAT_ADDR) |=> stat[0])
      else $error("status flag lost");

endmodule

// >>> dv/pcx_irq_ctrl_model.sv
// stand-in for the local interrupt controller on the far side
// assumes the interrupt and its accept pulse both live on mclk
`timescale 1ns/1ps
module pcx_irq_ctrl_model
(
   // clock
   input wire logic mclk,
   // interrupt request and its acceptance
   input wire logic irq,
   input wire logic take_en,
   output logic accept
);
   initial accept = 1'b0;
   // ----------------------------------------
   // acceptance
   // ----------------------------------------
   // one pulse per raised request, after a short latency, so the
   // masking that follows acceptance can be observed
   always
   begin
      @(posedge mclk);
      if (take_en && irq)
      begin
         repeat (2) @(posedge mclk);
         accept <= irq;
         @(posedge mclk);
         accept <= 1'b0;
         @(posedge mclk);
      end
   end
endmodule

// >>> dv/pcx_perf_counter_tb.sv
// self-checking bench of the queue-group counter block
// assumes pcx_consts.svh and pcx_pkg compiled first
`timescale 1ns/1ps
`include "pcx_consts.svh"
module pcx_perf_counter_tb
   import pcx_pkg::*;
;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   pcx_addr_t awa = 8'h00;
   pcx_addr_t ara = 8'h00;
   pcx_word_t wd = 32'h0;
   pcx_word_t rdat;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic awr, wr_rdy, bv, arr, rv, irq, acc;
   logic take_en = 1'b0;
   logic [1:0] brsp, rrsp;
   logic [15:0] evt = 16'h0;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #50 mclk = ~mclk;

   pcx_perf_counter pcx_perf_counter_inst (.mclk(mclk), .reset(reset),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
      .s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .event_in(evt), .counter_overflow_irq(irq), .irq_accept(acc));

   pcx_irq_ctrl_model pcx_irq_ctrl_model_inst (.mclk(mclk), .irq(irq), .take_en(take_en), .accept(acc));

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         finish_test();
      end
   end

   // ----------------------------------------
   // bus and stimulus helpers
   // ----------------------------------------
   task automatic wr(input pcx_addr_t a, input pcx_word_t d, input logic [1:0] er = `PCX_RESP_OKAY);
      @(posedge mclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
      end while (!(bv && bre));
      bre <= 1'b0;
      chk(brsp, er);
   endtask

   task automatic rd(input pcx_addr_t a, output pcx_word_t d, output logic [1:0] r);
      @(posedge mclk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (arv && arr) arv <= 1'b0;
      end while (!(rv && rre));
      d = rdat;
      r = rrsp;
      rre <= 1'b0;
   endtask

   task automatic rchk(input pcx_addr_t a, input pcx_word_t e);
      pcx_word_t d;
      logic [1:0] r;
      rd(a, d, r);
      chk({30'h0, r}, {30'h0, `PCX_RESP_OKAY});
      chk(d, e);
   endtask

   task automatic ev(input logic [15:0] m, input int n = 1);
      @(posedge mclk);
      evt <= m;
      repeat (n) @(posedge mclk);
      evt <= 16'h0;
   endtask

   // irq follows status within a few edges; never assumed exact here
   task automatic irq_is(input logic e);
      for (int i = 0; i < 8 && irq !== e; i++) @(posedge mclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_map();
      pcx_word_t d;
      logic [1:0] r;
      rchk(`PCX_STAT_ADDR, 32'h0);
      wr(8'h5c, 32'h1, `PCX_RESP_SLVERR);
      rd(8'h5c, d, r);
      chk({30'h0, r}, {30'h0, `PCX_RESP_SLVERR});
      chk(d, 32'h0);
      $display("t_map done");
   endtask

   task automatic t_wrap_irq();
      wr(`PCX_SEL_BASE, 32'h1);
      wr(`PCX_CNT_BASE, 32'hffff_ffff);
      wr(`PCX_MASK_ADDR, 32'h1);
      wr(`PCX_CFG_BASE, 32'h5);
      ev(16'h0002);
      rchk(`PCX_CNT_BASE, 32'h0);
      rchk(`PCX_CFG_BASE, 32'h8000_0005);
      rchk(`PCX_STAT_ADDR, 32'h0);
      irq_is(1'b0);
      ev(16'h0002);
      rchk(`PCX_STAT_ADDR, 32'h1);
      rchk(`PCX_CNT_BASE, 32'h1);
      irq_is(1'b1);
      take_en <= 1'b1;
      irq_is(1'b0);
      rchk(`PCX_CTRL_ADDR, 32'h1);
      take_en <= 1'b0;
      wr(`PCX_CTRL_ADDR, 32'h1);
      irq_is(1'b1);
      wr(`PCX_STAT_ADDR, 32'h1);
      irq_is(1'b0);
      wr(`PCX_CFG_BASE, 32'h5);
      rchk(`PCX_CFG_BASE, 32'h5);
      wr(`PCX_CNT_BASE, 32'hffff_ffff);
      ev(16'h0002, 2);
      rchk(`PCX_STAT_ADDR, 32'h1);
      rchk(`PCX_CNT_BASE, 32'h1);
      wr(`PCX_STAT_ADDR, 32'h1);
      wr(`PCX_CFG_BASE, 32'h0);
      $display("t_wrap_irq done");
   endtask

   task automatic t_force_null();
      wr(`PCX_SEL_BASE + 8'h04, 32'h2);
      wr(`PCX_CNT_BASE + 8'h08, 32'h10);
      wr(`PCX_MASK_ADDR, 32'h4);
      wr(`PCX_CFG_BASE + 8'h08, 32'hd);
      ev(16'h0004);
      rchk(`PCX_STAT_ADDR, 32'h4);
      rchk(`PCX_CNT_BASE + 8'h08, 32'h11);
      irq_is(1'b1);
      wr(`PCX_STAT_ADDR, 32'h4);
      irq_is(1'b0);
      ev(16'h0004);
      rchk(`PCX_STAT_ADDR, 32'h4);
      wr(`PCX_STAT_ADDR, 32'h4);
      wr(`PCX_SEL_BASE + 8'h04, 32'h0);
      wr(`PCX_CFG_BASE + 8'h08, 32'h1);
      ev(16'hffff);
      rchk(`PCX_CNT_BASE + 8'h08, 32'h12);
      wr(`PCX_CFG_BASE + 8'h08, 32'h0);
      $display("t_force_null done");
   endtask

   task automatic t_ext_chain();
      wr(`PCX_CFG_BASE + 8'h04, 32'h800);
      rchk(`PCX_CFG_BASE + 8'h04, 32'h0);
      wr(`PCX_SEL_BASE + 8'h08, 32'h3);
      wr(`PCX_CNT_BASE + 8'h10, 32'hffff_ffff);
      wr(`PCX_CFG_BASE + 8'h10, 32'h1);
      wr(`PCX_CNT_BASE, 32'h0);
      wr(`PCX_CFG_BASE, 32'h800);
      ev(16'h0008);
      rchk(`PCX_CFG_BASE + 8'h10, 32'h8000_0001);
      ev(16'h0002);
      rchk(`PCX_CNT_BASE, 32'h1);
      wr(`PCX_CFG_BASE, 32'h2);
      ev(16'h0002);
      rchk(`PCX_CNT_BASE, 32'h1);
      wr(`PCX_CFG_BASE, 32'h800);
      ev(16'h0002);
      rchk(`PCX_CNT_BASE, 32'h2);
      wr(`PCX_CFG_BASE + 8'h10, 32'h1);
      ev(16'h0002);
      rchk(`PCX_CNT_BASE, 32'h2);
      wr(`PCX_CNT_BASE + 8'h14, 32'hffff_ffff);
      wr(`PCX_CFG_BASE + 8'h0c, 32'h800);
      wr(`PCX_CFG_BASE + 8'h14, 32'h1);
      ev(16'h0008);
      rchk(`PCX_CFG_BASE + 8'h14, 32'h8000_0001);
      wr(`PCX_SEL_BASE + 8'h04, 32'h2);
      ev(16'h0004);
      rchk(`PCX_CNT_BASE + 8'h0c, 32'h1);
      $display("t_ext_chain done");
   endtask

   initial
   begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      t_map();
      t_wrap_irq();
      t_force_null();
      t_ext_chain();
      finish_test();
   end
endmodule
